/* File: tpec_pkg.sv */
// Package for the two-phase event counter: constants, states and carriers.
// Assumes a single 100 MHz clock domain and no software-visible bus.
package tpec_pkg;

  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic DIR_RST = 1'b1;
  localparam int unsigned N_PHASES = 2;

  // One-hot run states.
  typedef enum logic [2:0] {
    TPEC_IDLE = 3'h1,
    TPEC_ARMED = 3'h2,
    TPEC_COUNTING = 3'h4
  } tpec_run_e;

  // Per-phase sampled level and edge flags.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tpec_phase_s;

  // Software-side write of the timer value register.
  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } tpec_wr_s;

  // Complete state of the counter module.
  typedef struct packed {
    tpec_run_e run;
    logic [15:0] count;
    logic [15:0] reload;
    logic up_dir;
    logic irq;
    logic active;
  } tpec_state_s;

endpackage : tpec_pkg

/* File: tpec_phase_sync.sv */
// Two-flop synchroniser with edge detector for one phase input pin.
// Assumes the pin is asynchronous to mclk; edges are seen two cycles late.
`timescale 1ns/10ps
`default_nettype none

module tpec_phase_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pin,
  output tpec_pkg::tpec_phase_s phase
);

  typedef struct packed {
    logic [1:0] sync;
    logic prev;
  } tpec_sync_s;

  tpec_sync_s state_r;
  tpec_sync_s state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sync = {state_r.sync[0], pin};
    // The edge detector looks at the second stage only, never the first.
    state_nxt.prev = state_r.sync[1];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '{sync: tpec_pkg::SYNC_RST, prev: 1'b0};
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  assign phase.level = state_r.sync[1];
  assign phase.rise = state_r.sync[1] & ~state_r.prev;
  assign phase.fall = ~state_r.sync[1] & state_r.prev;

endmodule : tpec_phase_sync

`default_nettype wire

/* File: tpec_counter.sv */
// Two-phase event counter: one 16-bit channel fed by a quadrature pair.
// Assumes software drives the start flag, mode bits and value writes on
// mclk; the two phase pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Setting the start flag runs the counter; clearing it stops counting.
// - Overflow counting up or underflow counting down raises the interrupt.
// - Down-counting divides the event rate by n plus one.
// - Reading the value register returns the live counter contents.
// - Stopped, or started before any event, a write loads reload and counter.
// - After the first event, a write loads only reload; counter takes it later.
// - Normal mode, phase B high: A rising counts up, A falling down.
// - Times-four mode: A rising while B high makes every edge count up.
// - Times-four mode: A falling while B high makes every edge count down.
// - Wrap reloads from reload register, or free-running just keeps counting.
// - Up-counting divides the event rate by FFFFh minus n plus one.
module tpec_counter (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic count_start_flag,
  input wire logic quad_x4_mode,
  input wire logic free_run_mode,
  input wire tpec_pkg::tpec_wr_s value_wr,
  output logic [15:0] count_value,
  output logic running,
  output logic counting_up,
  output logic timer_irq
);

  tpec_pkg::tpec_phase_s pa;
  tpec_pkg::tpec_phase_s pb;
  tpec_pkg::tpec_state_s state_r;
  tpec_pkg::tpec_state_s state_nxt;

  logic [tpec_pkg::N_PHASES-1:0] pins;
  tpec_pkg::tpec_phase_s phs [tpec_pkg::N_PHASES];

  assign pins = {phase_b_input, phase_a_input};

  // Both pins get the same two-flop synchroniser and edge detector.
  for (genvar i = 0; i < tpec_pkg::N_PHASES; i++)
  begin : g_phase
    tpec_phase_sync u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .pin(pins[i]),
      .phase(phs[i])
    );
  end

  assign pa = phs[0];
  assign pb = phs[1];

  logic ev_norm;
  logic ev_x4;
  logic up_x4;
  logic ev;
  logic ev_up;
  logic wrap;
  logic [15:0] stepped;
  logic [15:0] next_count;
  logic wr_to_count;

  // Normal processing counts only A's edges, and only while B is high;
  // edges of A with B low and every edge of B are ignored.
  always_comb
  begin
    ev_norm = pb.level & (pa.rise | pa.fall);
  end

  // Times-four processing: the direction is latched by A's edge while B
  // is high and then applies to every edge of both phases.
  always_comb
  begin
    ev_x4 = pa.rise | pa.fall | pb.rise | pb.fall;
    up_x4 = state_r.up_dir;
    if (pa.rise && pb.level)
    begin
      up_x4 = 1'b1;
    end
    else if (pa.fall && pb.level)
    begin
      up_x4 = 1'b0;
    end
  end

  // Both decodes run all the time; the mode level picks one of them.
  always_comb
  begin
    if (quad_x4_mode)
    begin
      ev = ev_x4;
      ev_up = up_x4;
    end
    else
    begin
      ev = ev_norm;
      ev_up = pa.rise;
    end
  end

  always_comb
  begin
    wrap = 1'b0;
    stepped = state_r.count;
    if (ev_up)
    begin
      wrap = (state_r.count == tpec_pkg::CNT_MAX);
      stepped = state_r.count + 16'h0001;
    end
    else
    begin
      wrap = (state_r.count == tpec_pkg::CNT_MIN);
      stepped = state_r.count - 16'h0001;
    end
  end

  // Reloading on wrap gives a period of n+1 events down and FFFFh-n+1
  // events up; free-running rolls over instead.
  always_comb
  begin
    next_count = stepped;
    if (wrap && !free_run_mode)
    begin
      next_count = state_r.reload;
    end
  end

  // A write reaches the counter only until the first counted event. A
  // write in the same cycle as the first event is treated as taken after
  // the event, so it lands only in the reload register.
  always_comb
  begin
    wr_to_count = 1'b0;
    case (state_r.run)
      tpec_pkg::TPEC_IDLE:
      begin
        wr_to_count = value_wr.wr;
      end
      tpec_pkg::TPEC_ARMED:
      begin
        wr_to_count = value_wr.wr & ~(ev & count_start_flag);
      end
      default:
      begin
        wr_to_count = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.irq = 1'b0;
    case (state_r.run)
      tpec_pkg::TPEC_IDLE:
      begin
        if (count_start_flag)
        begin
          state_nxt.run = tpec_pkg::TPEC_ARMED;
        end
      end
      tpec_pkg::TPEC_ARMED, tpec_pkg::TPEC_COUNTING:
      begin
        if (!count_start_flag)
        begin
          state_nxt.run = tpec_pkg::TPEC_IDLE;
        end
        else if (ev)
        begin
          state_nxt.run = tpec_pkg::TPEC_COUNTING;
          state_nxt.up_dir = ev_up;
          state_nxt.irq = wrap;
          // From here on a write goes to the reload register only.
          state_nxt.count = next_count;
        end
      end
      default:
      begin
        state_nxt.run = tpec_pkg::TPEC_IDLE;
      end
    endcase
    if (value_wr.wr)
    begin
      state_nxt.reload = value_wr.data;
    end
    if (wr_to_count)
    begin
      state_nxt.count = value_wr.data;
    end
    // Kept in a flop so that the running output needs no decode.
    state_nxt.active = (state_nxt.run != tpec_pkg::TPEC_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '{run: tpec_pkg::TPEC_IDLE, count: tpec_pkg::CNT_RST,
                   reload: tpec_pkg::RELOAD_RST, up_dir: tpec_pkg::DIR_RST,
                   irq: 1'b0, active: 1'b0};
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  assign count_value = state_r.count;
  assign running = state_r.active;
  assign counting_up = state_r.up_dir;
  assign timer_irq = state_r.irq;

endmodule : tpec_counter

`default_nettype wire

/* File: tpec_counter_props.sv */
// Port checker for tpec_counter, bound to every instance.
// Assumes mclk is the only clock and nrst resets all state.
`timescale 1ns/10ps
`default_nettype none
module tpec_counter_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic count_start_flag,
  input wire logic quad_x4_mode,
  input wire tpec_pkg::tpec_wr_s value_wr,
  input wire logic [15:0] count_value,
  input wire logic running,
  input wire logic counting_up,
  input wire logic timer_irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_gate; ce && running && !quad_x4_mode && phase_b_input; endsequence
  sequence s_count; ##3 $changed(count_value); endsequence
  a_start_run: assert property (ce && count_start_flag |=> running)
    else $error("start ignored");
  a_idle_hold: assert property (!running && !value_wr.wr |=>
    $stable(count_value)) else $error("count moved while idle");
  a_write_load: assert property (ce && !running && value_wr.wr |=>
    count_value == $past(value_wr.data)) else $error("write lost");
  a_irq_wrap: assert property (timer_irq |->
    $past(count_value) == (counting_up ? 16'hffff : 16'h0000))
    else $error("irq without wrap");
  a_irq_pulse: assert property (timer_irq |=> !timer_irq)
    else $error("irq too long");
  a_step_one: assert property (running && !timer_irq &&
    !$past(value_wr.wr) && $changed(count_value) |-> count_value ==
    $past(count_value) + (counting_up ? 16'h0001 : 16'hffff))
    else $error("step not one");
  a_norm_up: assert property (s_gate ##0 $rose(phase_a_input) |->
    s_count ##0 counting_up) else $error("no up count");
  a_norm_dn: assert property (s_gate ##0 $fell(phase_a_input) |->
    s_count ##0 !counting_up) else $error("no down count");
endmodule : tpec_counter_props
bind tpec_counter tpec_counter_props u_props (
  .mclk, .nrst, .ce, .phase_a_input, .phase_b_input, .count_start_flag,
  .quad_x4_mode, .value_wr, .count_value, .running, .counting_up, .timer_irq
);
`default_nettype wire

/* File: tpec_quad_src.sv */
// Encoder model: one quadrature step per step pulse.
// Assumes steps are spaced well apart on mclk.
`timescale 1ns/10ps
`default_nettype none
module tpec_quad_src (
  input wire logic mclk,
  input wire logic step,
  input wire logic fwd,
  output logic a,
  output logic b
);
  logic [1:0] pos_r = 2'h0;
  // Gray order moves one phase at a time, so no edge is ambiguous.
  always_ff @(posedge mclk)
    if (step)
      pos_r <= fwd ? pos_r + 2'h1 : pos_r - 2'h1;
  assign a = pos_r[1];
  assign b = pos_r[1] ^ pos_r[0];
endmodule : tpec_quad_src
`default_nettype wire

/* File: tpec_counter_tb_top.sv */
// Self-checking bench for tpec_counter.
// Assumes tpec_quad_src stands in for the encoder on both phase pins.
`timescale 1ns/10ps
`default_nettype none
module tpec_counter_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic flag = 1'b0;
  logic x4 = 1'b0;
  logic fr = 1'b0;
  logic step = 1'b0;
  logic fwd = 1'b0;
  logic ce = 1'b1;
  logic a, b, run, up, irq;
  logic [15:0] cv;
  tpec_pkg::tpec_wr_s wr = '0;
  int mismatches = 0;
  int n_tests = 0;
  int irqs = 0;
  int irq_base = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (irq === 1'b1) irqs <= irqs + 1;
  tpec_quad_src src (.mclk, .step, .fwd, .a, .b);
  tpec_counter dut (.mclk, .nrst, .ce, .phase_a_input(a),
    .phase_b_input(b), .count_start_flag(flag), .quad_x4_mode(x4),
    .free_run_mode(fr), .value_wr(wr), .count_value(cv), .running(run),
    .counting_up(up), .timer_irq(irq));
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask : check
  task automatic mv(logic d, int n);
    repeat (n)
    begin
      step <= 1'b1;
      fwd <= d;
      @(posedge mclk);
      step <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask : mv
  // Stops, writes v while stopped, then restarts; rebases the irq tally.
  task automatic load(logic [15:0] v);
    flag <= 1'b0;
    @(posedge mclk);
    wr <= '{wr: 1'b1, data: v};
    @(posedge mclk);
    wr <= '{wr: 1'b0, data: v};
    flag <= 1'b1;
    irq_base = irqs;
    repeat (2) @(posedge mclk);
  endtask : load
  task automatic t_stop;
    check("reset count", cv, 16'h0000);
    load(16'h0005);
    check("loaded", cv, 16'h0005);
    check("running", {15'h0, run}, 16'h0001);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_normal;
    mv(1'b1, 4);
    check("up one", cv, 16'h0006);
    wr <= '{wr: 1'b1, data: 16'h0009};
    @(posedge mclk);
    wr <= '{wr: 1'b0, data: 16'h0009};
    repeat (2) @(posedge mclk);
    check("write ran", cv, 16'h0006);
    mv(1'b0, 4);
    check("down one", cv, 16'h0005);
    mv(1'b0, 24);
    check("reload", cv, 16'h0009);
    check("irqs", 16'(irqs - irq_base), 16'h0001);
    $display("t_normal done");
  endtask : t_normal
  task automatic t_down;
    load(16'h0001);
    mv(1'b0, 16);
    check("down wrap", cv, 16'h0001);
    check("irqs", 16'(irqs - irq_base), 16'h0002);
    $display("t_down done");
  endtask : t_down
  task automatic t_up(logic f, logic [15:0] ev, logic [15:0] ei);
    fr <= f;
    load(16'hfffe);
    mv(1'b1, 16);
    check("up wrap", cv, ev);
    check("irqs", 16'(irqs - irq_base), ei);
    $display("t_up done");
  endtask : t_up
  task automatic t_x4;
    fr <= 1'b0;
    x4 <= 1'b1;
    load(16'h0010);
    mv(1'b1, 2);
    check("x4 up", cv, 16'h0012);
    check("x4 dir up", {15'h0, up}, 16'h0001);
    mv(1'b0, 4);
    check("x4 down", cv, 16'h000e);
    check("x4 dir dn", {15'h0, up}, 16'h0000);
    ce <= 1'b0;
    mv(1'b1, 1);
    check("frozen", cv, 16'h000e);
    ce <= 1'b1;
    repeat (4) @(posedge mclk);
    check("thawed", cv, 16'h000d);
    flag <= 1'b0;
    mv(1'b1, 4);
    check("stopped", cv, 16'h000d);
    $display("t_x4 done");
  endtask : t_x4
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_stop();
    t_normal();
    t_down();
    t_up(1'b1, 16'h0002, 16'h0001);
    t_up(1'b0, 16'hfffe, 16'h0002);
    t_x4();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tpec_counter_tb_top
`default_nettype wire
